/* core_model.sv */
// Behavioural core that issues one operation per clock to the status block.
// Assumes each call starts just after a rising clock edge.
`timescale 1ns/100ps
`default_nettype none
module core_model (
	// Clock
	input wire logic clock,
	// Request to the status block
	output var cpu_status_pkg::coreReq_t coreReq
);
	import cpu_status_pkg::*;
	initial coreReq = '0;
	task automatic issue(input aluOp_t op, input logic slp, input logic d,
		input logic [7:0] a, input logic [7:0] b);
		coreReq <= '{1'b1, op, slp, d, a, b};
		@(posedge clock);
	endtask
	task automatic rest();
		coreReq <= '0;
	endtask
endmodule
`default_nettype wire

/* cpu_status_flags_defs.svh */
// Constants for the processor status flags register.
// Assumes a 32-bit AHB-Lite register bus with word-aligned registers.
`ifndef CPU_STATUS_FLAGS_DEFS_SVH
`define CPU_STATUS_FLAGS_DEFS_SVH
`define STAT_OFFSET 32'h0000_0000
`define STAT_IPAGE_BIT 7
`define STAT_DPAGE_HI 6
`define STAT_DPAGE_LO 5
`define STAT_EXPIRY_BIT 4
`define STAT_SLEEP_BIT 3
`define STAT_Z_BIT 2
`define STAT_NIBBLE_BIT 1
`define STAT_C_BIT 0
`define STAT_RESET 8'h18
`define HTRANS_NONSEQ 2'h2
`define HRESP_OKAY 1'h0
`endif

/* cpu_status_flags_register.sv */
// Processor status flags register with its flag-producing adder path.
// Assumes core requests and bus inputs are synchronous to clock.
//
// The placing of the registers and register access over AHB-Lite were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "cpu_status_flags_defs.svh"
module cpu_status_flags_register (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// AHB-Lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Core execution
	input wire cpu_status_pkg::coreReq_t coreReq,
	input wire logic watchdogTimeout,
	output logic [7:0] aluResult,
	output logic aluValid,
	// Address formation
	input wire cpu_status_pkg::addrReq_t addrReq,
	output logic [8:0] directAddr,
	output logic [8:0] indirectAddr,
	output logic [7:0] statusOut
);
	import cpu_status_pkg::*;

	default clocking cb @(posedge clock); endclocking
	default disable iff (reset);

	// ************************************************
	// Helpers
	// ************************************************
	function automatic logic isArith(input aluOp_t op);
		isArith = (op == OP_ADD) || (op == OP_SUB);
	endfunction

	function automatic logic isRotate(input aluOp_t op);
		isRotate = (op == OP_ROTR) || (op == OP_ROTL);
	endfunction

	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic [7:0] aluResult_r;
	logic aluValid_r;
	logic [31:0] hrdata_r;
	logic busWrite_r;
	logic busRead_r;
	logic busHit_r;

	// ************************************************
	// ALU flag path
	// ************************************************
	logic [7:0] operandB;
	logic carryIn;
	logic [8:0] sum9;
	logic [4:0] sum5;
	logic [7:0] result;
	logic reqGo;

	assign reqGo = coreReq.valid;

	always_comb begin
		operandB = (coreReq.op == OP_SUB) ? ~coreReq.opB : coreReq.opB;
		carryIn = (coreReq.op == OP_SUB);
		sum9 = {1'b0, coreReq.opA} + {1'b0, operandB} + {8'h00, carryIn};
		sum5 = {1'b0, coreReq.opA[3:0]} + {1'b0, operandB[3:0]} + {4'h0, carryIn};
		case (coreReq.op)
			OP_ADD,
			OP_SUB: begin
				result = sum9[7:0];
			end
			OP_ROTR: begin
				result = {status_r[`STAT_C_BIT], coreReq.opA[7:1]};
			end
			OP_ROTL: begin
				result = {coreReq.opA[6:0], status_r[`STAT_C_BIT]};
			end
			OP_CLR: begin
				result = 8'h00;
			end
			default: begin
				result = coreReq.opA;
			end
		endcase
	end

	// ************************************************
	// Status next state
	// ************************************************
	always_comb begin
		status_nxt = status_r;
		// Software write through the bus; cause flags protected
		if (busWrite_r && busHit_r) begin
			status_nxt[7:5] = hwdata[7:5];
			status_nxt[2:0] = hwdata[2:0];
		end
		// Instruction write to status overrides the bus
		if (reqGo && coreReq.destStatus && coreReq.op != OP_NONE && coreReq.op != OP_WDTCLR) begin
			status_nxt[7:5] = result[7:5];
			// Flag-affecting ops never write the arithmetic flags directly
			if (coreReq.op == OP_WRITE) begin
				status_nxt[2:0] = result[2:0];
			end
		end
		// Flag updates take priority over written data
		if (reqGo) begin
			case (coreReq.op)
				OP_ADD,
				OP_SUB: begin
					status_nxt[`STAT_Z_BIT] = (sum9[7:0] == 8'h00);
					status_nxt[`STAT_NIBBLE_BIT] = sum5[4];
					status_nxt[`STAT_C_BIT] = sum9[8];
				end
				OP_LOGIC: begin
					status_nxt[`STAT_Z_BIT] = (result == 8'h00);
				end
				OP_ROTR: begin
					status_nxt[`STAT_C_BIT] = coreReq.opA[0];
				end
				OP_ROTL: begin
					status_nxt[`STAT_C_BIT] = coreReq.opA[7];
				end
				OP_CLR: begin
					status_nxt[`STAT_Z_BIT] = 1'b1;
				end
				OP_WDTCLR: begin
					status_nxt[`STAT_EXPIRY_BIT] = 1'b1;
					status_nxt[`STAT_SLEEP_BIT] = 1'b1;
				end
				default: begin
				end
			endcase
			if (coreReq.sleep) begin
				status_nxt[`STAT_EXPIRY_BIT] = 1'b1;
				status_nxt[`STAT_SLEEP_BIT] = 1'b0;
			end
		end
		// Timeout wins over a same-cycle set
		if (watchdogTimeout) begin
			status_nxt[`STAT_EXPIRY_BIT] = 1'b0;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			status_r <= `STAT_RESET;
		end else begin
			status_r <= status_nxt;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			aluResult_r <= 8'h00;
			aluValid_r <= 1'b0;
		end else begin
			aluResult_r <= reqGo ? result : aluResult_r;
			aluValid_r <= reqGo && coreReq.op != OP_NONE;
		end
	end

	assign aluResult = aluResult_r;
	assign aluValid = aluValid_r;
	assign statusOut = status_r;

	// ************************************************
	// Data address formation
	// ************************************************
	assign directAddr = {status_r[`STAT_DPAGE_HI:`STAT_DPAGE_LO], addrReq.dirOffset};
	assign indirectAddr = {status_r[`STAT_IPAGE_BIT], addrReq.pointer};

	// ************************************************
	// AHB-Lite slave
	// ************************************************
	logic addrPhase;
	assign addrPhase = hsel && hready && htrans == `HTRANS_NONSEQ;

	always_ff @(posedge clock) begin
		if (reset) begin
			busWrite_r <= 1'b0;
			busRead_r <= 1'b0;
			busHit_r <= 1'b0;
		end else if (hready) begin
			busWrite_r <= addrPhase && hwrite;
			busRead_r <= addrPhase && !hwrite;
			busHit_r <= addrPhase && haddr == `STAT_OFFSET;
		end
	end

	always_ff @(posedge clock) begin
		if (reset) begin
			hrdata_r <= 32'h0000_0000;
		end else if (addrPhase && !hwrite) begin
			hrdata_r <= (haddr == `STAT_OFFSET) ? {24'h000000, status_nxt} : 32'h0000_0000;
		end
	end

	assign hrdata = hrdata_r;
	assign hreadyout = 1'b1;
	assign hresp = `HRESP_OKAY;

	// ************************************************
	// Checks
	// ************************************************
	property p_reset_value;
		$fell(reset) |-> status_r[7:3] == 5'b00011;
	endproperty
	a_reset_value: assert property (@(posedge clock) p_reset_value) else $error("bad reset");

	property p_timeout;
		watchdogTimeout |=> !status_r[`STAT_EXPIRY_BIT];
	endproperty
	a_timeout: assert property (p_timeout) else $error("expiry flag not cleared");

	property p_watchdog_clear;
		reqGo && coreReq.op == OP_WDTCLR && !coreReq.sleep && !watchdogTimeout
			|=> status_r[`STAT_EXPIRY_BIT] && status_r[`STAT_SLEEP_BIT];
	endproperty
	a_watchdog_clear: assert property (p_watchdog_clear) else $error("watchdog clear flags wrong");

	property p_sleep;
		reqGo && coreReq.sleep |=> !status_r[`STAT_SLEEP_BIT];
	endproperty
	a_sleep: assert property (p_sleep) else $error("sleep flag not cleared");

	property p_cause_ro;
		!reqGo && !watchdogTimeout |=> $stable(status_r[4:3]);
	endproperty
	a_cause_ro: assert property (p_cause_ro) else $error("cause flag written");

	property p_add_flags;
		reqGo && isArith(coreReq.op) && coreReq.op == OP_ADD
			|=> status_r[2:0] == {8'($past(coreReq.opA) + $past(coreReq.opB)) == 8'h00,
				5'($past(coreReq.opA[3:0])) + 5'($past(coreReq.opB[3:0])) > 5'h0F,
				9'($past(coreReq.opA)) + 9'($past(coreReq.opB)) > 9'h0FF};
	endproperty
	a_add_flags: assert property (p_add_flags) else $error("arith flags wrong");

	property p_sub_borrow;
		reqGo && coreReq.op == OP_SUB
			|=> status_r[2:0] == {$past(coreReq.opA) == $past(coreReq.opB),
				$past(coreReq.opA[3:0]) >= $past(coreReq.opB[3:0]),
				$past(coreReq.opA) >= $past(coreReq.opB)};
	endproperty
	a_sub_borrow: assert property (p_sub_borrow) else $error("no-borrow not one");

	property p_guarded_write;
		reqGo && coreReq.destStatus && !(busWrite_r && busHit_r)
			&& (coreReq.op == OP_LOGIC || coreReq.op == OP_CLR)
			|=> status_r[1:0] == $past(status_r[1:0]);
	endproperty
	a_guarded_write: assert property (p_guarded_write) else $error("guarded flags written");

	property p_rotate;
		reqGo && isRotate(coreReq.op)
			|=> status_r[`STAT_C_BIT] == (($past(coreReq.op) == OP_ROTR) ? $past(coreReq.opA[0])
				: $past(coreReq.opA[7]));
	endproperty
	a_rotate: assert property (p_rotate) else $error("rotate carry wrong");

	property p_clear_file;
		reqGo && coreReq.op == OP_CLR && coreReq.destStatus
			|=> status_r[7:5] == 3'h0 && status_r[`STAT_Z_BIT];
	endproperty
	a_clear_file: assert property (p_clear_file) else $error("clear file wrong");

	property p_plain_write;
		reqGo && coreReq.op == OP_WRITE && coreReq.destStatus && !coreReq.sleep
			|=> status_r[2:0] == $past(coreReq.opA[2:0]);
	endproperty
	a_plain_write: assert property (p_plain_write) else $error("plain write altered");

	property p_address;
		directAddr[8:7] == status_r[6:5] && indirectAddr[8] == status_r[7];
	endproperty
	a_address: assert property (p_address) else $error("bank prefix wrong");

	c_sub: cover property (reqGo && coreReq.op == OP_SUB);
	c_timeout: cover property (watchdogTimeout);
	c_bus_write: cover property (busWrite_r && busHit_r);
	c_bus_read: cover property (busRead_r && busHit_r);
	c_clear_status: cover property (reqGo && coreReq.op == OP_CLR && coreReq.destStatus);

endmodule
`default_nettype wire

/* cpu_status_pkg.sv */
// Types shared by the status flags register and its surroundings.
// Assumes the core issues at most one operation per clock.
`default_nettype none
package cpu_status_pkg;
	typedef enum logic [8:0] {
		OP_NONE = 9'h001,
		OP_ADD = 9'h002,
		OP_SUB = 9'h004,
		OP_LOGIC = 9'h008,
		OP_ROTR = 9'h010,
		OP_ROTL = 9'h020,
		OP_CLR = 9'h040,
		OP_WRITE = 9'h080,
		OP_WDTCLR = 9'h100
	} aluOp_t;
	typedef struct packed {
		logic valid;
		aluOp_t op;
		logic sleep;
		logic destStatus;
		logic [7:0] opA;
		logic [7:0] opB;
	} coreReq_t;
	typedef struct packed {
		logic [6:0] dirOffset;
		logic [7:0] pointer;
	} addrReq_t;
endpackage
`default_nettype wire

/* tb_top.sv */
// Self-checking bench for the status flags register.
// Assumes the package and core model are compiled first.
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import cpu_status_pkg::*;
	// ********************
	// Signals
	// ********************
	logic clock = 1'b0;
	logic reset = 1'b1;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic timeoutPulse = 1'b0;
	logic rdPend = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [2:0] hsize = 3'h2;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	addrReq_t addrReq = '0;
	coreReq_t coreReq;
	logic hreadyout, hresp, aluValid;
	logic [31:0] hrdata;
	logic [7:0] aluResult, statusOut, st, r;
	logic [8:0] directAddr, indirectAddr;
	logic [16:0] aluE;
	logic [16:0] aluQ[$];
	logic [31:0] rdQ[$];
	int err_total = 0;
	int checks_done = 0;
	always #2 clock = ~clock;
	cpu_status_flags_register u_cpu_status_flags_register (.clock(clock), .reset(reset),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
		.hrdata(hrdata), .coreReq(coreReq), .watchdogTimeout(timeoutPulse), .aluResult(aluResult),
		.aluValid(aluValid), .addrReq(addrReq), .directAddr(directAddr),
		.indirectAddr(indirectAddr), .statusOut(statusOut));
	core_model u_core_model (.clock(clock), .coreReq(coreReq));
	// ********************
	// Tasks
	// ********************
	task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge clock); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge clock); while (hreadyout !== 1'b1);
	endtask
	task automatic rd(input logic [31:0] a, input logic [31:0] e);
		rdQ.push_back(e);
		bus(1'b0, a, 32'h0);
	endtask
	task automatic wr(input logic [31:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
		if (a == 32'h0) st = {d[7:5], st[4:3], d[2:0]};
	endtask
	task automatic op(input aluOp_t o, input logic d, input logic [7:0] a, input logic [7:0] b);
		logic [8:0] s;
		logic [4:0] h;
		logic [7:0] bb;
		logic [2:0] f;
		f = st[2:0];
		r = a;
		bb = (o == OP_SUB) ? ~b : b;
		s = a + bb + (o == OP_SUB);
		h = a[3:0] + bb[3:0] + (o == OP_SUB);
		case (o)
			OP_ADD, OP_SUB: begin
				r = s[7:0];
				f = {r == 8'h00, h[4], s[8]};
			end
			OP_LOGIC: f[2] = (r == 8'h00);
			OP_ROTR: begin
				r = {st[0], a[7:1]};
				f[0] = a[0];
			end
			OP_ROTL: begin
				r = {a[6:0], st[0]};
				f[0] = a[7];
			end
			OP_CLR: begin
				r = 8'h00;
				f[2] = 1'b1;
			end
			default: ;
		endcase
		if (d && o != OP_WDTCLR) st[7:5] = r[7:5];
		st[2:0] = (d && o == OP_WRITE) ? r[2:0] : f;
		if (o == OP_WDTCLR) st[4:3] = 2'b11;
		aluQ.push_back({o != OP_WDTCLR, r, st});
		u_core_model.issue(o, 1'b0, d, a, b);
	endtask
	task automatic endt(input string n);
		$display("test %s done", n);
	endtask
	// ********************
	// Output monitor
	// ********************
	always @(posedge clock) begin
		if (aluValid === 1'b1) begin
			aluE = aluQ.pop_front();
			cmp("status", aluE[7:0], statusOut);
			if (aluE[16]) cmp("result", aluE[15:8], aluResult);
		end
		if (hreadyout === 1'b1) begin
			if (rdPend) cmp("hrdata", rdQ.pop_front(), hrdata);
			if (rdPend) cmp("hresp", 32'h0, hresp);
			rdPend <= hsel && htrans == 2'h2 && !hwrite;
		end
	end
	// ********************
	// Sequence
	// ********************
	initial begin
		void'($urandom(97359));
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		st = 8'h18;
		rd(32'h0, 32'h18);
		rd(32'h4, 32'h0);
		wr(32'h4, 32'hFF);
		wr(32'h0, 32'hE7);
		rd(32'h0, st);
		endt("bus");
		for (int i = 0; i < 8; i++) begin
			wr(32'h0, i << 5);
			addrReq <= '{7'($urandom), 8'($urandom)};
			#1;
			cmp("direct", {st[6:5], addrReq.dirOffset}, directAddr);
			cmp("indirect", {st[7], addrReq.pointer}, indirectAddr);
			@(posedge clock);
		end
		endt("paging");
		op(OP_ADD, 1'b0, 8'h0F, 8'h01);
		op(OP_SUB, 1'b0, 8'h42, 8'h42);
		op(OP_SUB, 1'b0, 8'h10, 8'h01);
		for (int i = 0; i < 16; i++) begin
			op(i[0] ? OP_SUB : OP_ADD, 1'b0, 8'($urandom), 8'($urandom));
		end
		op(OP_ROTR, 1'b0, 8'h81, 8'h00);
		op(OP_ROTL, 1'b0, 8'h81, 8'h00);
		op(OP_LOGIC, 1'b0, 8'h00, 8'h00);
		op(OP_WRITE, 1'b1, 8'hFF, 8'h00);
		op(OP_CLR, 1'b1, 8'h00, 8'h00);
		op(OP_ADD, 1'b1, 8'hF0, 8'h20);
		op(OP_LOGIC, 1'b1, 8'hA5, 8'h00);
		u_core_model.rest();
		endt("alu");
		@(posedge clock);
		u_core_model.issue(OP_NONE, 1'b1, 1'b0, 8'h00, 8'h00);
		u_core_model.rest();
		st[4:3] = 2'b10;
		rd(32'h0, st);
		timeoutPulse <= 1'b1;
		@(posedge clock);
		timeoutPulse <= 1'b0;
		st[4] = 1'b0;
		rd(32'h0, st);
		op(OP_WDTCLR, 1'b0, 8'h00, 8'h00);
		u_core_model.rest();
		endt("reset cause");
		reset <= 1'b1;
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rd(32'h0, 32'h18);
		repeat (3) @(posedge clock);
		cmp("pending", 32'h0, aluQ.size() + rdQ.size());
		endt("second reset");
		finish_test();
	end
	initial begin
		#20000;
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
